//--- hw/iexb_pkg.sv
// Purpose: shared constants and types of the integer execute and branch unit
// Assumes: registers on a plain strobe port, 32-bit data, word aligned offsets
// Notes: all offsets are byte addresses
package iexb_pkg;
  localparam int          DW          = 32;
  localparam int          AW          = 6;
  // register byte offsets
  localparam logic [5:0]  OFF_OPA     = 6'h00;
  localparam logic [5:0]  OFF_OPB     = 6'h04;
  localparam logic [5:0]  OFF_YREG    = 6'h08;
  localparam logic [5:0]  OFF_CMD     = 6'h0C;
  localparam logic [5:0]  OFF_RESULT  = 6'h10;
  localparam logic [5:0]  OFF_STATUS  = 6'h14;
  localparam logic [5:0]  OFF_PC      = 6'h18;
  localparam logic [5:0]  OFF_NPC     = 6'h1C;
  localparam logic [5:0]  OFF_FLUSH   = 6'h20;
  // command field positions
  localparam int          CMD_OP_LO   = 0;
  localparam int          CMD_OP_HI   = 4;
  localparam int          CMD_IMM     = 5;
  localparam int          CMD_SETCC   = 6;
  localparam int          CMD_ANNUL   = 7;
  localparam int          CMD_DISCARD = 8;
  localparam int          CMD_CND_LO  = 9;
  localparam int          CMD_CND_HI  = 12;
  // branch conditions
  localparam logic [3:0]  CND_NEVER   = 4'h0;
  localparam logic [3:0]  CND_EQ      = 4'h1;
  localparam logic [3:0]  CND_LT      = 4'h3;
  localparam logic [3:0]  CND_ALWAYS  = 4'h8;
  localparam logic [3:0]  CND_NE      = 4'h9;
  localparam logic [3:0]  CND_GE      = 4'hB;
  // status field positions
  localparam int          ST_ICC_LO   = 0;
  localparam int          ST_TRAP_LO  = 4;
  localparam int          ST_ANNUL    = 6;
  localparam int          ST_FLUSH    = 7;
  // reset and constants
  localparam logic [31:0] PC_RST      = 32'h0000_0000;
  localparam logic [31:0] NPC_RST     = 32'h0000_0004;
  localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
  localparam logic [31:0] ZERO_W      = 32'h0000_0000;
  localparam logic [31:0] UMAX_W      = 32'hFFFF_FFFF;
  localparam logic [31:0] SMAX_W      = 32'h7FFF_FFFF;
  localparam logic [31:0] SMIN_W      = 32'h8000_0000;
  localparam int          SIMM_BITS   = 13;
  localparam int          HIC_SHIFT   = 10;
  localparam logic [1:0]  TRAP_NONE   = 2'h0;
  localparam logic [1:0]  TRAP_DIVZ   = 2'h1;
  localparam logic [1:0]  TRAP_TAG    = 2'h2;

  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_SLL, OP_SRL, OP_SRA,
    OP_SETHC, OP_UMUL, OP_SMUL, OP_UDIV, OP_SDIV,
    OP_TADD, OP_TSUB, OP_TADDTV, OP_TSUBTV, OP_BRANCH, OP_CALL, OP_JLINK
  } iexb_op_t;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } iexb_bus_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } iexb_icc_t;
endpackage

//--- hw/iexb_core.sv
// Purpose: integer execute and control transfer unit driven through registers
// Assumes: one command per CMD write, result one cycle later; memories external
// Notes: flush waits for the memory system before any further command runs
// How it works
// - fetch held until memory confirms the flush
// - set_high_constant loads upper 22 result bits
// - two operands, result written or discarded
// - shift distance from immediate or register
// - 32x32 multiply, signed or unsigned, 64-bit
// - 64 by 32 divide gives 32-bit quotient
// - multiply and divide may update condition codes
// - zero divisor traps, no result
// - low two operand bits are tag
// - overflow or nonzero tag sets V
// - trapping tagged ops trap on same condition
// - delay slot executes before the target
// - delay slot always fetched, even branch-always
// - annul skips slot: untaken, or branch-always
// - jump_and_link target is sum of operands
// - branch and call relative to own PC
// - branch displacement reaches plus minus 8 Mbytes
// - call uses 30-bit word displacement
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module iexb_core
  import iexb_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               nrst,
  // register port
  input  wire iexb_pkg::iexb_bus_t bus,
  output logic [31:0]             rdata,
  // memory system
  input  wire logic               flush_done,
  output logic                    flush_req,
  output logic [31:0]             flush_addr,
  output logic [31:0]             fetch_pc,
  // events
  output logic                    trap
);
  import iexb_pkg::*;

  logic [31:0] opa_r, opb_r, y_r, res_r, pc_r, npc_r, rdata_r, faddr_r;
  iexb_icc_t   icc_r;
  logic [1:0]  cause_r;
  logic        annul_pend_r, trap_r, freq_r, fbusy_r, fdone_s1_r, fdone_s2_r;

  // decode
  wire logic     wr_cmd   = bus.wr && bus.addr == OFF_CMD;
  wire logic     cmd_go   = wr_cmd && !fbusy_r;
  wire logic     fl_go    = bus.wr && bus.addr == OFF_FLUSH && !fbusy_r;
  wire iexb_op_t op_w     = iexb_op_t'(bus.wdata[CMD_OP_HI:CMD_OP_LO]);
  wire logic     use_imm  = bus.wdata[CMD_IMM];
  wire logic     set_cc   = bus.wdata[CMD_SETCC];
  wire logic     annul_b  = bus.wdata[CMD_ANNUL];
  wire logic     discard  = bus.wdata[CMD_DISCARD];
  wire logic [3:0] cnd    = bus.wdata[CMD_CND_HI:CMD_CND_LO];
  wire logic [31:0] simm  = {{(32-SIMM_BITS){opb_r[SIMM_BITS-1]}},
                             opb_r[SIMM_BITS-1:0]};
  wire logic [31:0] op2   = use_imm ? simm : opb_r;
  wire logic [4:0]  shamt = op2[4:0];

  // arithmetic
  wire logic [32:0] add_w = {1'b0, opa_r} + {1'b0, op2};
  wire logic [32:0] sub_w = {1'b0, opa_r} - {1'b0, op2};
  wire logic add_ov = (opa_r[31] == op2[31]) && (add_w[31] != opa_r[31]);
  wire logic sub_ov = (opa_r[31] != op2[31]) && (sub_w[31] != opa_r[31]);
  wire logic tag_bad = (|opa_r[1:0]) || (|op2[1:0]);
  wire logic is_tsub = op_w == OP_TSUB || op_w == OP_TSUBTV;
  wire logic tag_ov  = (is_tsub ? sub_ov : add_ov) || tag_bad;
  wire logic is_tag  = op_w inside {OP_TADD, OP_TSUB, OP_TADDTV, OP_TSUBTV};
  wire logic is_tv   = op_w == OP_TADDTV || op_w == OP_TSUBTV;
  wire logic is_div  = op_w == OP_UDIV || op_w == OP_SDIV;
  wire logic divz    = is_div && op2 == ZERO_W;

  // multiply, sign handled by operand extension
  wire logic [63:0] uprod = {32'h0000_0000, opa_r} * {32'h0000_0000, op2};
  wire logic signed [63:0] sprod = $signed(opa_r) * $signed(op2);

  // divide; a zero divisor is replaced so no X leaks into the result path
  wire logic [63:0] dvd   = {y_r, opa_r};
  wire logic [31:0] dsr   = divz ? WORD_STEP : op2;
  wire logic [63:0] uq    = dvd / {32'h0000_0000, dsr};
  wire logic signed [63:0] sq = $signed(dvd) / $signed({{32{dsr[31]}}, dsr});
  wire logic uq_ov = |uq[63:32];
  wire logic sq_ov = sq[63:31] != {33{sq[31]}};
  wire logic [31:0] uq_w = uq_ov ? UMAX_W : uq[31:0];
  wire logic [31:0] sq_w = !sq_ov ? sq[31:0] : (sq[63] ? SMIN_W : SMAX_W);

  // control transfer targets
  wire logic [31:0] br_tgt = pc_r + {{8{opb_r[21]}}, opb_r[21:0], 2'b00};
  wire logic [31:0] cl_tgt = pc_r + {opb_r[29:0], 2'b00};
  wire logic [31:0] jl_tgt = opa_r + op2;
  logic cnd_true;
  always_comb begin
    unique case (cnd)
      CND_ALWAYS: cnd_true = 1'b1;
      CND_EQ:     cnd_true = icc_r.z;
      CND_NE:     cnd_true = !icc_r.z;
      CND_LT:     cnd_true = icc_r.n ^ icc_r.v;
      CND_GE:     cnd_true = !(icc_r.n ^ icc_r.v);
      default:    cnd_true = 1'b0;
    endcase
  end
  wire logic is_br   = op_w == OP_BRANCH;
  wire logic take_w  = (is_br && cnd_true) || op_w == OP_CALL || op_w == OP_JLINK;
  wire logic [31:0] tgt_w = is_br ? br_tgt : (op_w == OP_CALL ? cl_tgt : jl_tgt);
  wire logic annul_w = is_br && annul_b && (!cnd_true || cnd == CND_ALWAYS);

  // result, flags and trap of one command
  logic [31:0] lo_w, hi_w;
  iexb_icc_t   icc_w;
  logic        wr_w, cc_w, trap_w;
  logic [1:0]  cause_w;
  always_comb begin
    lo_w    = ZERO_W;
    hi_w    = y_r;
    icc_w   = icc_r;
    wr_w    = !discard;
    cc_w    = set_cc;
    trap_w  = 1'b0;
    cause_w = TRAP_NONE;
    unique case (op_w)
      OP_ADD: begin
        lo_w  = add_w[31:0];
        icc_w = '{add_w[31], add_w[31:0] == ZERO_W, add_ov, add_w[32]};
      end
      OP_SUB: begin
        lo_w  = sub_w[31:0];
        icc_w = '{sub_w[31], sub_w[31:0] == ZERO_W, sub_ov, sub_w[32]};
      end
      OP_AND:   lo_w = opa_r & op2;
      OP_OR:    lo_w = opa_r | op2;
      OP_XOR:   lo_w = opa_r ^ op2;
      OP_SLL:   lo_w = opa_r << shamt;
      OP_SRL:   lo_w = opa_r >> shamt;
      OP_SRA:   lo_w = 32'($signed(opa_r) >>> shamt);
      OP_SETHC: begin
        lo_w = {opb_r[DW-HIC_SHIFT-1:0], {HIC_SHIFT{1'b0}}};
        cc_w = 1'b0;
      end
      OP_UMUL, OP_SMUL: begin
        {hi_w, lo_w} = op_w == OP_UMUL ? uprod : sprod;
        icc_w = '{lo_w[31], lo_w == ZERO_W, 1'b0, 1'b0};
      end
      OP_UDIV, OP_SDIV: begin
        lo_w  = op_w == OP_UDIV ? uq_w : sq_w;
        icc_w = '{lo_w[31], lo_w == ZERO_W,
                  op_w == OP_UDIV ? uq_ov : sq_ov, 1'b0};
        if (divz) begin
          trap_w  = 1'b1;
          cause_w = TRAP_DIVZ;
        end
      end
      OP_TADD, OP_TSUB, OP_TADDTV, OP_TSUBTV: begin
        lo_w  = is_tsub ? sub_w[31:0] : add_w[31:0];
        icc_w = '{lo_w[31], lo_w == ZERO_W, tag_ov,
                  is_tsub ? sub_w[32] : add_w[32]};
        cc_w  = 1'b1;
        if (is_tv && tag_ov) begin
          trap_w  = 1'b1;
          cause_w = TRAP_TAG;
        end
      end
      OP_CALL, OP_JLINK: begin
        lo_w = pc_r;
        cc_w = 1'b0;
      end
      default: begin
        wr_w = 1'b0;
        cc_w = 1'b0;
      end
    endcase
    if (trap_w) begin
      wr_w = 1'b0;
      cc_w = 1'b0;
    end
  end

  // register read mux
  wire logic [31:0] st_w = {24'h00_0000, fbusy_r, annul_pend_r, cause_r, icc_r};
  logic [31:0] rd_w;
  always_comb begin
    unique case (bus.addr)
      OFF_OPA:    rd_w = opa_r;
      OFF_OPB:    rd_w = opb_r;
      OFF_YREG:   rd_w = y_r;
      OFF_RESULT: rd_w = res_r;
      OFF_STATUS: rd_w = st_w;
      OFF_PC:     rd_w = pc_r;
      OFF_NPC:    rd_w = npc_r;
      OFF_FLUSH:  rd_w = faddr_r;
      default:    rd_w = ZERO_W;
    endcase
  end

  // operand and read registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      opa_r   <= ZERO_W;
      opb_r   <= ZERO_W;
      rdata_r <= ZERO_W;
    end else begin
      if (bus.wr && bus.addr == OFF_OPA) opa_r <= bus.wdata;
      if (bus.wr && bus.addr == OFF_OPB) opb_r <= bus.wdata;
      rdata_r <= bus.rd ? rd_w : ZERO_W;
    end
  end

  // execute and sequence; an annulled slot only steps the PC
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pc_r         <= PC_RST;
      npc_r        <= NPC_RST;
      res_r        <= ZERO_W;
      y_r          <= ZERO_W;
      icc_r        <= '0;
      cause_r      <= TRAP_NONE;
      trap_r       <= 1'b0;
      annul_pend_r <= 1'b0;
    end else begin
      trap_r <= 1'b0;
      if (bus.wr && bus.addr == OFF_YREG) y_r <= bus.wdata;
      if (cmd_go) begin
        pc_r <= npc_r;
        if (annul_pend_r) begin
          npc_r        <= npc_r + WORD_STEP;
          annul_pend_r <= 1'b0;
        end else begin
          npc_r        <= take_w ? tgt_w : npc_r + WORD_STEP;
          annul_pend_r <= annul_w;
          trap_r       <= trap_w;
          cause_r      <= cause_w;
          if (wr_w) res_r <= lo_w;
          if (wr_w) y_r <= hi_w;
          if (cc_w) icc_r <= icc_w;
        end
      end
    end
  end

  // flush handshake; done comes from the memory clock so it is synchronised
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fdone_s1_r <= 1'b0;
      fdone_s2_r <= 1'b0;
      freq_r     <= 1'b0;
      fbusy_r    <= 1'b0;
      faddr_r    <= ZERO_W;
    end else begin
      fdone_s1_r <= flush_done;
      fdone_s2_r <= fdone_s1_r;
      if (fl_go) begin
        faddr_r <= bus.wdata;
        freq_r  <= 1'b1;
        fbusy_r <= 1'b1;
      end else if (freq_r && fdone_s2_r) begin
        freq_r <= 1'b0;
      end else if (!freq_r && !fdone_s2_r) begin
        fbusy_r <= 1'b0;
      end
    end
  end

  assign rdata      = rdata_r;
  assign flush_req  = freq_r;
  assign flush_addr = faddr_r;
  assign fetch_pc   = pc_r;
  assign trap       = trap_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_live_cmd;
    cmd_go && !annul_pend_r;
  endsequence
  sequence s_transfer;
    s_live_cmd and take_w;
  endsequence
  sequence s_link;
    s_live_cmd and (op_w == OP_CALL || op_w == OP_JLINK) && !discard;
  endsequence

  a_high_const: assert property (s_live_cmd and op_w == OP_SETHC && !discard
    |=> res_r == {$past(opb_r[21:0]), 10'h000})
    else $error("set_high_constant result wrong");
  a_umul_product: assert property (s_live_cmd and op_w == OP_UMUL && !discard
    |=> {y_r, res_r} == $past(uprod))
    else $error("unsigned product wrong");
  a_divzero_trap: assert property (s_live_cmd and divz
    |=> trap_r && $stable(res_r) && cause_r == TRAP_DIVZ)
    else $error("zero divisor did not trap");
  a_tag_overflow: assert property (s_live_cmd and is_tag && tag_bad
    |=> icc_r.v || trap_r)
    else $error("tag bits did not set overflow");
  a_tagged_trap: assert property (s_live_cmd and is_tv && tag_ov
    |=> trap_r && cause_r == TRAP_TAG ##1 (!trap_r || $past(cmd_go)))
    else $error("trapping tagged op did not trap");
  a_delay_slot: assert property (s_transfer
    |=> fetch_pc == $past(npc_r) && npc_r == $past(tgt_w))
    else $error("delay slot skipped or target wrong");
  a_annul_squash: assert property (cmd_go && annul_pend_r
    |=> $stable(res_r) && $stable(icc_r) && !trap_r && !annul_pend_r)
    else $error("annulled slot had an effect");
  a_annul_always: assert property (s_live_cmd and is_br && annul_b && cnd == CND_ALWAYS
    |=> annul_pend_r)
    else $error("branch-always did not annul its slot");
  a_flush_hold: assert property (fbusy_r && wr_cmd
    |=> $stable(pc_r) && $stable(npc_r))
    else $error("command ran during flush");
  a_flush_start: assert property (fl_go
    |=> freq_r && fbusy_r ##1 fbusy_r)
    else $error("flush request not raised");

  // targets and links; squashed slots are kept out by s_live_cmd
  // back-to-back trapping commands may hold trap high, so pulses allow that
  a_untaken_step: assert property (s_live_cmd and is_br && !cnd_true
    |=> npc_r == $past(npc_r) + WORD_STEP)
    else $error("untaken branch moved npc");
  a_slot_fetch: assert property (s_live_cmd and is_br && cnd == CND_ALWAYS
    |=> fetch_pc == $past(npc_r) && npc_r == $past(br_tgt))
    else $error("branch-always skipped its slot");
  a_link_value: assert property (s_link
    |=> res_r == $past(pc_r))
    else $error("link value is not the transfer pc");
  a_jl_target: assert property (s_live_cmd and op_w == OP_JLINK
    |=> npc_r == $past(opa_r) + $past(op2))
    else $error("jump_and_link target wrong");
  a_call_target: assert property (s_live_cmd and op_w == OP_CALL
    |=> npc_r == $past(pc_r) + {$past(opb_r[29:0]), 2'b00})
    else $error("call target wrong");
  a_cc_keep: assert property (s_live_cmd and !set_cc && !is_tag
    |=> $stable(icc_r))
    else $error("condition codes changed without set");
  a_trap_pulse: assert property (trap_r
    |=> !trap_r || $past(cmd_go))
    else $error("trap held without a command");
  a_smul_product: assert property (s_live_cmd and op_w == OP_SMUL && !discard
    |=> {y_r, res_r} == $past(sprod))
    else $error("signed product wrong");
endmodule
`default_nettype wire

//--- verification/iexb_mem_model.sv
// Purpose: memory-system stand-in that answers instruction flush requests
// Assumes: done is held high until the request drops, then goes low
// Notes: lat sets how slowly the answer comes, so both prompt and slow cases run
`timescale 1ns/100ps
`default_nettype none
module iexb_mem_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // flush link
  input  wire logic       flush_req,
  input  wire logic [3:0] lat,
  output logic            flush_done
);
  logic [3:0] wait_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wait_r     <= 4'h0;
      flush_done <= 1'b0;
    end else if (!flush_req) begin
      wait_r     <= 4'h0;
      flush_done <= 1'b0;
    end else if (wait_r == lat) begin
      flush_done <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- verification/integer_execute_and_branch_test.sv
// Purpose: self-checking bench of the integer execute and branch unit
// Assumes: register port strobes driven by non-blocking assignment after an edge
// Notes: reads queue their expectation; a monitor compares one cycle after
`timescale 1ns/100ps
`default_nettype none
module integer_execute_and_branch_test;
  import iexb_pkg::*;
  localparam logic [31:0] F_IMM = 32'h0000_0020;
  localparam logic [31:0] F_CC  = 32'h0000_0040;
  localparam logic [31:0] F_AN  = 32'h0000_0080;
  localparam logic [31:0] F_DIS = 32'h0000_0100;
  localparam logic [31:0] F_ALW = 32'h0000_1000;
  localparam logic [31:0] ALL   = 32'hFFFF_FFFF;
  logic        core_clk, nrst, flush_done, flush_req, trap;
  logic        rd_d1 = 1'b0;
  iexb_bus_t   bus;
  logic [31:0] rdata, flush_addr, fetch_pc, pc_m, npc_m, res_m, a, b, t, m;
  logic [31:0] s_r = 32'h0000_0017;
  logic [63:0] p;
  logic [3:0]  lat;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  int          fails, n_checks, n_trap, cyc, n;

  iexb_core i_dut (.core_clk(core_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .flush_done(flush_done), .flush_req(flush_req), .flush_addr(flush_addr),
    .fetch_pc(fetch_pc), .trap(trap));
  iexb_mem_model i_mem (.core_clk(core_clk), .nrst(nrst), .flush_req(flush_req),
    .lat(lat), .flush_done(flush_done));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function logic [31:0] rnd();
    s_r ^= s_r << 13;
    s_r ^= s_r >> 17;
    s_r ^= s_r << 5;
    return s_r;
  endfunction

  function automatic logic [31:0] sx13(input logic [31:0] v);
    return {{19{v[12]}}, v[12:0]};
  endfunction

  function automatic logic [31:0] alu(input int op, input logic [31:0] x, y);
    case (op)
      0: return x + y;
      1: return x - y;
      2: return x & y;
      3: return x | y;
      4: return x ^ y;
      5: return x << y[4:0];
      6: return x >> y[4:0];
      default: return $signed(x) >>> y[4:0];
    endcase
  endfunction

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    bus.wr    <= 1'b1;
    bus.addr  <= ad;
    bus.wdata <= d;
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] ad, input logic [31:0] e, input logic [31:0] mk);
    @(posedge core_clk);
    eq.push_back(e & mk);
    mq.push_back(mk);
    bus.rd   <= 1'b1;
    bus.addr <= ad;
    @(posedge core_clk);
    bus.rd <= 1'b0;
  endtask

  // command with operands; the bench tracks pc and npc itself
  task automatic ex(input iexb_op_t op, input logic [31:0] fl, x, y, input logic tk,
                    input logic [31:0] tg);
    logic [31:0] nx;
    wr(OFF_OPA, x);
    wr(OFF_OPB, y);
    wr(OFF_CMD, fl | 32'(op));
    nx    = tk ? tg : npc_m + WORD_STEP;
    pc_m  = npc_m;
    npc_m = nx;
  endtask

  always @(posedge core_clk) begin
    if (rd_d1) begin
      m = mq.pop_front();
      cmp(rdata & m, eq.pop_front());
    end
    if (trap === 1'b1) n_trap++;
    rd_d1 <= bus.rd;
    cyc++;
    if (cyc > 5000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    nrst = 1'b0;
    bus = '0;
    lat = 4'h1;
    pc_m = PC_RST;
    npc_m = NPC_RST;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    cmp(fetch_pc, PC_RST);
    rd(OFF_NPC, NPC_RST, ALL);
    rd(6'h3C, ZERO_W, ALL);
    for (int i = 0; i < 8; i++) begin
      a = rnd();
      b = rnd();
      ex(iexb_op_t'(i), i[0] ? F_IMM : ZERO_W, a, b, 1'b0, ZERO_W);
      res_m = alu(i, a, i[0] ? sx13(b) : b);
      rd(OFF_RESULT, res_m, ALL);
    end
    ex(OP_ADD, F_DIS, 32'h0000_0001, 32'h0000_0002, 1'b0, ZERO_W);
    rd(OFF_RESULT, res_m, ALL);
    b = rnd();
    ex(OP_SETHC, ZERO_W, ZERO_W, b, 1'b0, ZERO_W);
    res_m = {b[21:0], 10'h000};
    rd(OFF_RESULT, res_m, ALL);
    ex(OP_UMUL, F_CC, ZERO_W, rnd(), 1'b0, ZERO_W);
    rd(OFF_STATUS, 32'h0000_0004, 32'h0000_000F);
    for (int i = 9; i < 11; i++) begin
      a = rnd();
      b = rnd();
      ex(iexb_op_t'(i), ZERO_W, a, b, 1'b0, ZERO_W);
      if (i == 9) p = {32'h0, a} * {32'h0, b};
      else p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      res_m = p[31:0];
      rd(OFF_RESULT, res_m, ALL);
      rd(OFF_YREG, p[63:32], ALL);
    end
    rd(OFF_STATUS, 32'h0000_0004, 32'h0000_000F);
    wr(OFF_YREG, 32'h0000_0001);
    ex(OP_UDIV, ZERO_W, ZERO_W, 32'h0000_0004, 1'b0, ZERO_W);
    res_m = 32'h4000_0000;
    rd(OFF_RESULT, res_m, ALL);
    a = rnd();
    b = rnd() | 32'h0000_0001;
    wr(OFF_YREG, {32{a[31]}});
    ex(OP_SDIV, ZERO_W, a, b, 1'b0, ZERO_W);
    res_m = $signed(a) / $signed(b);
    rd(OFF_RESULT, res_m, ALL);
    ex(OP_UDIV, F_CC, a, ZERO_W, 1'b0, ZERO_W);
    rd(OFF_RESULT, res_m, ALL);
    rd(OFF_STATUS, 32'h0000_0010, 32'h0000_0030);
    // tagged cases: operands, result, expected overflow flag
    ex(OP_TADD, ZERO_W, 32'h0000_0004, 32'h0000_0008, 1'b0, ZERO_W);
    rd(OFF_STATUS, ZERO_W, 32'h0000_0002);
    ex(OP_TADD, ZERO_W, 32'h0000_0005, 32'h0000_0008, 1'b0, ZERO_W);
    rd(OFF_RESULT, 32'h0000_000D, ALL);
    rd(OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
    ex(OP_TSUB, ZERO_W, SMIN_W, 32'h0000_0004, 1'b0, ZERO_W);
    rd(OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
    res_m = 32'h7FFF_FFFC;
    ex(OP_TADDTV, ZERO_W, 32'h0000_0004, 32'h0000_0002, 1'b0, ZERO_W);
    rd(OFF_RESULT, res_m, ALL);
    rd(OFF_STATUS, 32'h0000_0020, 32'h0000_0030);
    ex(OP_TSUBTV, ZERO_W, SMIN_W, 32'h0000_0004, 1'b0, ZERO_W);
    rd(OFF_RESULT, res_m, ALL);
    b = 32'h0020_0000;
    t = pc_m + ({{10{b[21]}}, b[21:0]} << 2);
    ex(OP_BRANCH, F_ALW, ZERO_W, b, 1'b1, t);
    ex(OP_ADD, ZERO_W, 32'h0000_0003, 32'h0000_0004, 1'b0, ZERO_W);
    res_m = 32'h0000_0007;
    rd(OFF_RESULT, res_m, ALL);
    rd(OFF_PC, pc_m, ALL);
    b = 32'h001F_FFFF;
    t = pc_m + ({{10{b[21]}}, b[21:0]} << 2);
    ex(OP_BRANCH, F_ALW | F_AN, ZERO_W, b, 1'b1, t);
    ex(OP_TADDTV, F_CC, 32'h0000_0001, 32'h0000_0001, 1'b0, ZERO_W);
    rd(OFF_RESULT, res_m, ALL);
    ex(OP_BRANCH, F_AN, ZERO_W, 32'h0000_0004, 1'b0, ZERO_W);
    ex(OP_ADD, ZERO_W, 32'h0000_0005, 32'h0000_0005, 1'b0, ZERO_W);
    rd(OFF_RESULT, res_m, ALL);
    rd(OFF_PC, pc_m, ALL);
    b = 32'h3FFF_FFFF;
    res_m = pc_m;
    ex(OP_CALL, ZERO_W, ZERO_W, b, 1'b1, pc_m + {b[29:0], 2'b00});
    rd(OFF_RESULT, res_m, ALL);
    rd(OFF_NPC, npc_m, ALL);
    a = rnd() & 32'hFFFF_FFFC;
    res_m = pc_m;
    ex(OP_JLINK, F_IMM, a, 32'h0000_1000, 1'b1, a + sx13(32'h0000_1000));
    rd(OFF_RESULT, res_m, ALL);
    rd(OFF_NPC, npc_m, ALL);
    // conditional branches on codes set by a subtract
    ex(OP_SUB, F_CC, 32'h0000_0005, 32'h0000_0005, 1'b0, ZERO_W);
    res_m = ZERO_W;
    rd(OFF_STATUS, 32'h0000_0004, 32'h0000_000F);
    t = pc_m + 32'h0000_0010;
    ex(OP_BRANCH, 32'h0000_0200, ZERO_W, 32'h0000_0004, 1'b1, t);
    ex(OP_BRANCH, 32'h0000_1200, ZERO_W, 32'h0000_0008, 1'b0, ZERO_W);
    rd(OFF_PC, pc_m, ALL);
    rd(OFF_NPC, npc_m, ALL);
    ex(OP_BRANCH, F_AN | 32'h0000_0600, ZERO_W, 32'h0000_0004, 1'b0, ZERO_W);
    ex(OP_ADD, ZERO_W, 32'h0000_0003, 32'h0000_0004, 1'b0, ZERO_W);
    rd(OFF_RESULT, res_m, ALL);
    for (int k = 0; k < 2; k++) begin
      lat <= k ? 4'h9 : 4'h1;
      a = rnd();
      wr(OFF_FLUSH, a);
      wr(OFF_CMD, 32'(OP_ADD));
      cmp(32'(flush_req), 32'h0000_0001);
      rd(OFF_STATUS, 32'h0000_0080, 32'h0000_0080);
      rd(OFF_RESULT, res_m, ALL);
      cmp(flush_addr, a);
      n = 0;
      while (flush_req !== 1'b0 && n < 60) begin
        @(posedge core_clk);
        n++;
      end
      repeat (6) @(posedge core_clk);
      cmp(32'(flush_req), ZERO_W);
      rd(OFF_STATUS, ZERO_W, 32'h0000_0080);
    end
    rd(OFF_PC, pc_m, ALL);
    repeat (3) @(posedge core_clk);
    cmp(fetch_pc, pc_m);
    cmp(32'(n_trap), 32'h0000_0003);
    stop_test();
  end
endmodule
`default_nettype wire
